// File: sfm_pkg.sv
package sfm_pkg;
  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] SFM_FF_GAIN_OFS = 8'h00;
  localparam logic [7:0] SFM_FF_TIME_OFS = 8'h04;
  localparam logic [7:0] SFM_SW_SEL_OFS = 8'h08;
  localparam logic [7:0] SFM_TQ_LVL_OFS = 8'h0C;
  localparam logic [7:0] SFM_SPD_LVL_OFS = 8'h10;
  localparam logic [7:0] SFM_ACC_LVL_OFS = 8'h14;
  localparam logic [7:0] SFM_PERR_LVL_OFS = 8'h18;
  localparam logic [7:0] SFM_NOTCH_OFS = 8'h1C;
  localparam logic [7:0] SFM_TQ_LAG_OFS = 8'h20;
  localparam logic [7:0] SFM_STATUS_OFS = 8'h24;

  // ----------------------------------------------------------------
  // Setting limits and reset values
  // ----------------------------------------------------------------
  localparam logic [31:0] SFM_FF_GAIN_MAX = 32'h0000_0064;
  localparam logic [31:0] SFM_FF_GAIN_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_PERCENT_DIV = 32'h0000_0064;
  localparam logic [31:0] SFM_FF_TIME_MAX = 32'h0000_1900;
  localparam logic [31:0] SFM_FF_TIME_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_SW_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_TQ_LVL_MAX = 32'h0000_0320;
  localparam logic [31:0] SFM_TQ_LVL_RST = 32'h0000_00C8;
  localparam logic [31:0] SFM_SPD_LVL_MAX = 32'h0000_2710;
  localparam logic [31:0] SFM_SPD_LVL_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_ACC_LVL_MAX = 32'h0000_7530;
  localparam logic [31:0] SFM_ACC_LVL_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_PERR_LVL_MAX = 32'h0000_FFFF;
  localparam logic [31:0] SFM_PERR_LVL_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_NOTCH_RST = 32'h0000_0000;
  localparam logic [31:0] SFM_TQ_LAG_MAX = 32'h0000_FFFF;
  localparam logic [31:0] SFM_TQ_LAG_RST = 32'h0000_0064;

  // ----------------------------------------------------------------
  // Switch condition codes and notch digit positions
  // ----------------------------------------------------------------
  localparam logic [3:0] SFM_SW_TORQUE = 4'h0;
  localparam logic [3:0] SFM_SW_SPEED = 4'h1;
  localparam logic [3:0] SFM_SW_ACCEL = 4'h2;
  localparam logic [3:0] SFM_SW_POSERR = 4'h3;
  localparam logic [3:0] SFM_SW_OFF = 4'h4;
  localparam logic [3:0] SFM_NOTCH_ON = 4'h1;
  localparam int SFM_NOTCH1_LSB = 0;
  localparam int SFM_NOTCH2_LSB = 8;
  localparam int SFM_NOTCH_N = 2;

  // ----------------------------------------------------------------
  // Loop sample period: one filter step per 0.01 ms
  // ----------------------------------------------------------------
  localparam int SFM_CLK_PERIOD_NS = 8;
  localparam int SFM_TICK_NS = 10000;
  localparam int SFM_TICK_CYC = SFM_TICK_NS / SFM_CLK_PERIOD_NS;
  localparam logic [10:0] SFM_TICK_LAST = 11'(SFM_TICK_CYC - 1);

  // ----------------------------------------------------------------
  // Lag stage arithmetic
  // ----------------------------------------------------------------
  localparam int SFM_FRAC = 16;
  localparam logic [16:0] SFM_RECIP_ONE = 17'h1_0000;
  localparam logic [4:0] SFM_DIV_STEPS = 5'h11;

  typedef enum logic [0:0] {
    SFM_DIV_IDLE = 1'b0,
    SFM_DIV_RUN = 1'b1
  } sfm_div_state_t;
endpackage

// File: sfm_lag_if.sv
`timescale 1ns/1ps
interface sfm_lag_if;
  logic sample;
  logic signed [31:0] x;
  logic [15:0] tc;
  logic signed [31:0] y;

  modport stage (input sample, input x, input tc, output y);
  modport feed (output sample, output x, output tc, input y);
endinterface

// File: sfm_lag_stage.sv
`timescale 1ns/1ps
module sfm_lag_stage (
  input wire logic clk_i,
  input wire logic rst_i,
  sfm_lag_if.stage lag
);
  import sfm_pkg::*;

  // ----------------------------------------------------------------
  // Reciprocal of (tc + 1), found serially whenever tc changes
  // ----------------------------------------------------------------
  // A serial divider costs 17 cycles of latency but no wide divider;
  // the old factor stays in use meanwhile, far inside one sample.
  sfm_div_state_t st_ff, nxt_st;
  logic [16:0] recip_ff, nxt_recip;
  logic [15:0] tc_done_ff, nxt_tc_done;
  logic [16:0] den_ff, nxt_den;
  logic [17:0] rem_ff, nxt_rem;
  logic [16:0] quo_ff, nxt_quo;
  logic [4:0] cnt_ff, nxt_cnt;
  logic signed [31:0] y_ff, nxt_y;

  always_comb begin
    logic [17:0] trial;
    logic signed [32:0] diff;
    logic signed [50:0] prod;
    trial = '0;
    diff = '0;
    prod = '0;
    nxt_st = st_ff;
    nxt_recip = recip_ff;
    nxt_tc_done = tc_done_ff;
    nxt_den = den_ff;
    nxt_rem = rem_ff;
    nxt_quo = quo_ff;
    nxt_cnt = cnt_ff;
    unique case (st_ff)
      SFM_DIV_IDLE: begin
        if (lag.tc != tc_done_ff) begin
          nxt_st = SFM_DIV_RUN;
          nxt_tc_done = lag.tc;
          nxt_den = {1'b0, lag.tc} + 17'h0_0001;
          nxt_rem = '0;
          nxt_quo = '0;
          nxt_cnt = '0;
        end
      end
      SFM_DIV_RUN: begin
        trial = {rem_ff[16:0], SFM_RECIP_ONE[5'd16 - cnt_ff]};
        if (trial >= {1'b0, den_ff}) begin
          nxt_rem = trial - {1'b0, den_ff};
          nxt_quo = {quo_ff[15:0], 1'b1};
        end else begin
          nxt_rem = trial;
          nxt_quo = {quo_ff[15:0], 1'b0};
        end
        nxt_cnt = cnt_ff + 5'h01;
        if (cnt_ff == SFM_DIV_STEPS - 5'h01) begin
          nxt_st = SFM_DIV_IDLE;
          nxt_recip = nxt_quo;
        end
      end
    endcase
    // First-order lag: y += (x - y) / (tc + 1), tc counted in samples
    nxt_y = y_ff;
    if (lag.sample) begin
      diff = 33'(lag.x) - 33'(y_ff);
      prod = 51'(diff) * $signed({1'b0, recip_ff});
      nxt_y = y_ff + 32'(prod >>> SFM_FRAC);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= SFM_DIV_IDLE;
      recip_ff <= SFM_RECIP_ONE;
      tc_done_ff <= '0;
      den_ff <= '0;
      rem_ff <= '0;
      quo_ff <= '0;
      cnt_ff <= '0;
      y_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      recip_ff <= nxt_recip;
      tc_done_ff <= nxt_tc_done;
      den_ff <= nxt_den;
      rem_ff <= nxt_rem;
      quo_ff <= nxt_quo;
      cnt_ff <= nxt_cnt;
      y_ff <= nxt_y;
    end
  end

  assign lag.y = y_ff;
endmodule // sfm_lag_stage

// File: sfm_servo_ff_switch.sv
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module sfm_servo_ff_switch (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  input wire logic position_mode_i,
  input wire logic signed [31:0] ff_base_i,
  input wire logic signed [31:0] torque_ref_i,
  input wire logic signed [31:0] speed_ref_i,
  input wire logic signed [31:0] accel_ref_i,
  input wire logic signed [31:0] poserr_i,
  output logic signed [31:0] feedforward_o,
  output logic signed [31:0] torque_filt_o,
  output logic p_control_o
);
  import sfm_pkg::*;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lim);
    return (v > lim) ? lim : v;
  endfunction

  function automatic logic [31:0] mag(input logic signed [31:0] v);
    return v[31] ? 32'(-v) : 32'(v);
  endfunction

  // ----------------------------------------------------------------
  // Register file state
  // ----------------------------------------------------------------
  logic [31:0] ff_gain_ff, nxt_ff_gain;
  logic [31:0] ff_time_ff, nxt_ff_time;
  logic [31:0] sw_sel_ff, nxt_sw_sel;
  logic [31:0] tq_lvl_ff, nxt_tq_lvl;
  logic [31:0] spd_lvl_ff, nxt_spd_lvl;
  logic [31:0] acc_lvl_ff, nxt_acc_lvl;
  logic [31:0] perr_lvl_ff, nxt_perr_lvl;
  logic [31:0] notch_ff, nxt_notch;
  logic [31:0] tq_lag_ff, nxt_tq_lag;
  logic ack_ff, nxt_ack;
  logic [31:0] rdat_ff, nxt_rdat;
  logic p_ctl_ff, nxt_p_ctl;
  logic [10:0] tick_cnt_ff, nxt_tick_cnt;
  logic tick_ff, nxt_tick;
  logic signed [31:0] nd1_ff [SFM_NOTCH_N];
  logic signed [31:0] nd2_ff [SFM_NOTCH_N];
  logic signed [31:0] nxt_nd1 [SFM_NOTCH_N];
  logic signed [31:0] nxt_nd2 [SFM_NOTCH_N];
  logic signed [31:0] tq_out_ff, nxt_tq_out;
  logic wb_req;

  sfm_lag_if ff_lag ();
  sfm_lag_if tq_lag ();

  assign wb_req = cyc_i & stb_i & ~ack_ff;

  // ----------------------------------------------------------------
  // Wishbone register access
  // ----------------------------------------------------------------
  // Every access is answered one cycle after the request, unmapped
  // offsets included: those read zero and drop writes.
  always_comb begin
    logic [31:0] m;
    m = '0;
    nxt_ff_gain = ff_gain_ff;
    nxt_ff_time = ff_time_ff;
    nxt_sw_sel = sw_sel_ff;
    nxt_tq_lvl = tq_lvl_ff;
    nxt_spd_lvl = spd_lvl_ff;
    nxt_acc_lvl = acc_lvl_ff;
    nxt_perr_lvl = perr_lvl_ff;
    nxt_notch = notch_ff;
    nxt_tq_lag = tq_lag_ff;
    nxt_ack = wb_req;
    nxt_rdat = rdat_ff;
    if (wb_req && we_i) begin
      unique case (adr_i)
        SFM_FF_GAIN_OFS: begin
          m = lane_merge(ff_gain_ff, dat_i, sel_i);
          nxt_ff_gain = clamp(m, SFM_FF_GAIN_MAX);
        end
        SFM_FF_TIME_OFS: begin
          m = lane_merge(ff_time_ff, dat_i, sel_i);
          nxt_ff_time = clamp(m, SFM_FF_TIME_MAX);
        end
        SFM_SW_SEL_OFS: begin
          nxt_sw_sel = lane_merge(sw_sel_ff, dat_i, sel_i) & 32'h0000_000F;
        end
        SFM_TQ_LVL_OFS: begin
          m = lane_merge(tq_lvl_ff, dat_i, sel_i);
          nxt_tq_lvl = clamp(m, SFM_TQ_LVL_MAX);
        end
        SFM_SPD_LVL_OFS: begin
          m = lane_merge(spd_lvl_ff, dat_i, sel_i);
          nxt_spd_lvl = clamp(m, SFM_SPD_LVL_MAX);
        end
        SFM_ACC_LVL_OFS: begin
          m = lane_merge(acc_lvl_ff, dat_i, sel_i);
          nxt_acc_lvl = clamp(m, SFM_ACC_LVL_MAX);
        end
        SFM_PERR_LVL_OFS: begin
          m = lane_merge(perr_lvl_ff, dat_i, sel_i);
          nxt_perr_lvl = clamp(m, SFM_PERR_LVL_MAX);
        end
        SFM_NOTCH_OFS: begin
          nxt_notch = lane_merge(notch_ff, dat_i, sel_i) & 32'h0000_0F0F;
        end
        SFM_TQ_LAG_OFS: begin
          m = lane_merge(tq_lag_ff, dat_i, sel_i);
          nxt_tq_lag = clamp(m, SFM_TQ_LAG_MAX);
        end
        default: begin
        end
      endcase
    end
    if (wb_req && !we_i) begin
      unique case (adr_i)
        SFM_FF_GAIN_OFS: nxt_rdat = ff_gain_ff;
        SFM_FF_TIME_OFS: nxt_rdat = ff_time_ff;
        SFM_SW_SEL_OFS: nxt_rdat = sw_sel_ff;
        SFM_TQ_LVL_OFS: nxt_rdat = tq_lvl_ff;
        SFM_SPD_LVL_OFS: nxt_rdat = spd_lvl_ff;
        SFM_ACC_LVL_OFS: nxt_rdat = acc_lvl_ff;
        SFM_PERR_LVL_OFS: nxt_rdat = perr_lvl_ff;
        SFM_NOTCH_OFS: nxt_rdat = notch_ff;
        SFM_TQ_LAG_OFS: nxt_rdat = tq_lag_ff;
        SFM_STATUS_OFS: nxt_rdat = {30'h0, position_mode_i, p_ctl_ff};
        default: nxt_rdat = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ff_gain_ff <= SFM_FF_GAIN_RST;
      ff_time_ff <= SFM_FF_TIME_RST;
      sw_sel_ff <= SFM_SW_SEL_RST;
      tq_lvl_ff <= SFM_TQ_LVL_RST;
      spd_lvl_ff <= SFM_SPD_LVL_RST;
      acc_lvl_ff <= SFM_ACC_LVL_RST;
      perr_lvl_ff <= SFM_PERR_LVL_RST;
      notch_ff <= SFM_NOTCH_RST;
      tq_lag_ff <= SFM_TQ_LAG_RST;
      ack_ff <= 1'b0;
      rdat_ff <= '0;
    end else begin
      ff_gain_ff <= nxt_ff_gain;
      ff_time_ff <= nxt_ff_time;
      sw_sel_ff <= nxt_sw_sel;
      tq_lvl_ff <= nxt_tq_lvl;
      spd_lvl_ff <= nxt_spd_lvl;
      acc_lvl_ff <= nxt_acc_lvl;
      perr_lvl_ff <= nxt_perr_lvl;
      notch_ff <= nxt_notch;
      tq_lag_ff <= nxt_tq_lag;
      ack_ff <= nxt_ack;
      rdat_ff <= nxt_rdat;
    end
  end

  assign ack_o = ack_ff;
  assign dat_o = rdat_ff;

  // ----------------------------------------------------------------
  // Mode switch
  // ----------------------------------------------------------------
  // Evaluated every clock so a level write acts on the next edge.
  always_comb begin
    nxt_p_ctl = 1'b0;
    unique case (sw_sel_ff[3:0])
      SFM_SW_TORQUE: nxt_p_ctl = mag(torque_ref_i) > tq_lvl_ff;
      SFM_SW_SPEED: nxt_p_ctl = mag(speed_ref_i) > spd_lvl_ff;
      SFM_SW_ACCEL: nxt_p_ctl = mag(accel_ref_i) > acc_lvl_ff;
      SFM_SW_POSERR: nxt_p_ctl = position_mode_i && (mag(poserr_i) > perr_lvl_ff);
      SFM_SW_OFF: nxt_p_ctl = 1'b0;
      default: nxt_p_ctl = 1'b0;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      p_ctl_ff <= 1'b0;
    end else begin
      p_ctl_ff <= nxt_p_ctl;
    end
  end

  assign p_control_o = p_ctl_ff;

  // ----------------------------------------------------------------
  // Sample tick, one per 0.01 ms
  // ----------------------------------------------------------------
  always_comb begin
    nxt_tick = (tick_cnt_ff == SFM_TICK_LAST);
    nxt_tick_cnt = nxt_tick ? '0 : tick_cnt_ff + 11'h001;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_cnt_ff <= '0;
      tick_ff <= 1'b0;
    end else begin
      tick_cnt_ff <= nxt_tick_cnt;
      tick_ff <= nxt_tick;
    end
  end

  // ----------------------------------------------------------------
  // Feedforward path
  // ----------------------------------------------------------------
  // Outside position control the filter input is zero and the output is
  // gated to zero, so the term steps to zero while the filter decays.
  logic signed [63:0] ff_scaled;
  assign ff_scaled = (64'(ff_base_i) * $signed({1'b0, ff_gain_ff})) /
                     $signed({1'b0, SFM_PERCENT_DIV});
  assign ff_lag.sample = tick_ff;
  assign ff_lag.x = position_mode_i ? 32'(ff_scaled) : '0;
  assign ff_lag.tc = ff_time_ff[15:0];

  sfm_lag_stage u_ff_lag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lag(ff_lag.stage)
  );

  assign feedforward_o = position_mode_i ? ff_lag.y : '0;

  // ----------------------------------------------------------------
  // Torque reference filter: lag, then notch stages
  // ----------------------------------------------------------------
  assign tq_lag.sample = tick_ff;
  assign tq_lag.x = torque_ref_i;
  assign tq_lag.tc = tq_lag_ff[15:0];

  sfm_lag_stage u_tq_lag (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .lag(tq_lag.stage)
  );

  // Each notch is a two-sample comb, a null at a quarter of the rate;
  // its delay line always runs so enabling it causes no start glitch.
  always_comb begin
    logic signed [31:0] s;
    logic signed [32:0] sum;
    logic en;
    s = tq_lag.y;
    sum = '0;
    en = 1'b0;
    for (int k = 0; k < SFM_NOTCH_N; k++) begin
      nxt_nd1[k] = tick_ff ? s : nd1_ff[k];
      nxt_nd2[k] = tick_ff ? nd1_ff[k] : nd2_ff[k];
      en = (k == 0) ? (notch_ff[SFM_NOTCH1_LSB +: 4] == SFM_NOTCH_ON)
                    : (notch_ff[SFM_NOTCH2_LSB +: 4] == SFM_NOTCH_ON);
      sum = 33'(s) + 33'(nd2_ff[k]);
      s = en ? 32'(sum >>> 1) : s;
    end
    nxt_tq_out = tick_ff ? s : tq_out_ff;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int k = 0; k < SFM_NOTCH_N; k++) begin
        nd1_ff[k] <= '0;
        nd2_ff[k] <= '0;
      end
      tq_out_ff <= '0;
    end else begin
      for (int k = 0; k < SFM_NOTCH_N; k++) begin
        nd1_ff[k] <= nxt_nd1[k];
        nd2_ff[k] <= nxt_nd2[k];
      end
      tq_out_ff <= nxt_tq_out;
    end
  end

  assign torque_filt_o = tq_out_ff;
endmodule // sfm_servo_ff_switch

// File: sfm_servo_monitor.sv
`timescale 1ns/1ps
module sfm_servo_monitor
  import sfm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_i,
  input wire logic [3:0] sel_i,
  input wire logic ack_o,
  input wire logic position_mode_i,
  input wire logic signed [31:0] torque_ref_i,
  input wire logic signed [31:0] feedforward_o,
  input wire logic signed [31:0] torque_filt_o,
  input wire logic p_control_o
);
  // ----------------------------------------------------------------
  // Mirror of select and torque level; quiet after writes settle
  // ----------------------------------------------------------------
  logic [3:0] sel_ff;
  logic [3:0] nxt_sel;
  logic [31:0] lvl_ff;
  logic [31:0] nxt_lvl;
  logic [1:0] q_ff;
  logic [1:0] nxt_q;
  logic [10:0] hold_ff;
  logic [10:0] nxt_hold;
  logic [31:0] filt_ff;
  logic [31:0] tq_abs;
  logic wr_ev;
  logic tq_over;
  always_comb begin
    wr_ev = cyc_i && stb_i && we_i && ack_o && (sel_i == 4'hF);
    tq_abs = torque_ref_i[31] ? 32'(-torque_ref_i) : 32'(torque_ref_i);
    tq_over = tq_abs > lvl_ff;
    nxt_sel = sel_ff;
    nxt_lvl = lvl_ff;
    nxt_q = (q_ff == 2'h3) ? q_ff : q_ff + 2'h1;
    nxt_hold = (hold_ff == 11'h7FF) ? hold_ff : hold_ff + 11'h1;
    if (32'(torque_filt_o) != filt_ff) begin
      nxt_hold = 11'h0;
    end
    if (wr_ev) begin
      nxt_q = 2'h0;
      if (adr_i == SFM_SW_SEL_OFS) begin
        nxt_sel = dat_i[3:0];
      end
      if (adr_i == SFM_TQ_LVL_OFS) begin
        nxt_lvl = (dat_i > SFM_TQ_LVL_MAX) ? SFM_TQ_LVL_MAX : dat_i;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_ff <= SFM_SW_SEL_RST[3:0];
      lvl_ff <= SFM_TQ_LVL_RST;
      q_ff <= 2'h0;
      hold_ff <= 11'h0;
      filt_ff <= 32'h0;
    end else begin
      sel_ff <= nxt_sel;
      lvl_ff <= nxt_lvl;
      q_ff <= nxt_q;
      hold_ff <= nxt_hold;
      filt_ff <= 32'(torque_filt_o);
    end
  end
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ack_resp;
    cyc_i && stb_i && !ack_o |=> ack_o;
  endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("no ack after request");
  property p_ack_pulse;
    ack_o |=> !ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held too long");
  property p_ff_gate;
    !position_mode_i |-> feedforward_o == 32'sh0;
  endproperty
  a_ff_gate: assert property (p_ff_gate) else $error("feedforward outside position");
  // Quiet window hides the one-cycle uncertainty of when a new level acts
  property p_tq;
    q_ff == 2'h3 && sel_ff == SFM_SW_TORQUE |-> p_control_o == $past(tq_over);
  endproperty
  a_tq: assert property (p_tq) else $error("torque switch mismatch");
  property p_off;
    q_ff == 2'h3 && sel_ff >= SFM_SW_OFF |-> !p_control_o;
  endproperty
  a_off: assert property (p_off) else $error("switch active while disabled");
  property p_perr_mode;
    q_ff == 2'h3 && sel_ff == SFM_SW_POSERR && !$past(position_mode_i) |-> !p_control_o;
  endproperty
  a_perr_mode: assert property (p_perr_mode) else $error("poserr switch outside position");
  property p_rst;
    $past(rst_i) |-> !ack_o && !p_control_o && torque_filt_o == 32'sh0;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_filt_hold;
    32'(torque_filt_o) != filt_ff |-> hold_ff >= 11'h4B0;
  endproperty
  a_filt_hold: assert property (p_filt_hold) else $error("filter output between ticks");
  c_pctl: cover property ($rose(p_control_o));
  c_wr: cover property (wr_ev);
  c_ff: cover property (feedforward_o != 32'sh0);
endmodule // sfm_servo_monitor

bind sfm_servo_ff_switch sfm_servo_monitor u_mon (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .ack_o(ack_o),
  .position_mode_i(position_mode_i), .torque_ref_i(torque_ref_i),
  .feedforward_o(feedforward_o), .torque_filt_o(torque_filt_o), .p_control_o(p_control_o));

// File: sfm_host_model.sv
`timescale 1ns/1ps
module sfm_host_model (
  input wire logic clk_i,
  input wire logic ack_i,
  input wire logic [31:0] dat_i,
  output logic cyc_o,
  output logic stb_o,
  output logic we_o,
  output logic [7:0] adr_o,
  output logic [31:0] dat_o,
  output logic [3:0] sel_o
);
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    dat_o = 32'h0;
    sel_o = 4'h0;
  end
  // Single classic cycle; gains above 80 percent are only sent as range probes
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge clk_i);
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    dat_o <= d;
    sel_o <= 4'hF;
    do @(posedge clk_i); while (ack_i !== 1'b1);
    q = dat_i;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= 1'b0;
    dat_o <= ~d;
  endtask
endmodule // sfm_host_model

// File: testbench.sv
`timescale 1ns/1ps
module testbench;
  import sfm_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc, stb, we, ack;
  logic [7:0] adr;
  logic [31:0] wdat, rdat, q;
  logic [3:0] sel;
  logic pos = 1'b1;
  logic signed [31:0] ffb = 0, tq = 0, spd = 0, acc = 0, perr = 0;
  logic signed [31:0] ffo, tfo;
  logic pctl;
  int miscompares = 0;
  int tests_run = 0;
  logic [7:0] ofs [9] = '{SFM_FF_GAIN_OFS, SFM_FF_TIME_OFS, SFM_SW_SEL_OFS, SFM_TQ_LVL_OFS,
    SFM_SPD_LVL_OFS, SFM_ACC_LVL_OFS, SFM_PERR_LVL_OFS, SFM_NOTCH_OFS, SFM_TQ_LAG_OFS};
  logic [31:0] rstv [9] = '{SFM_FF_GAIN_RST, SFM_FF_TIME_RST, SFM_SW_SEL_RST, SFM_TQ_LVL_RST,
    SFM_SPD_LVL_RST, SFM_ACC_LVL_RST, SFM_PERR_LVL_RST, SFM_NOTCH_RST, SFM_TQ_LAG_RST};
  logic [31:0] topv [9] = '{SFM_FF_GAIN_MAX, SFM_FF_TIME_MAX, 32'h0000_000F, SFM_TQ_LVL_MAX,
    SFM_SPD_LVL_MAX, SFM_ACC_LVL_MAX, SFM_PERR_LVL_MAX, 32'h0000_0F0F, SFM_TQ_LAG_MAX};
  always #4 clk_i = ~clk_i;
  sfm_servo_ff_switch dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we),
    .adr_i(adr), .dat_i(wdat), .sel_i(sel), .dat_o(rdat), .ack_o(ack),
    .position_mode_i(pos), .ff_base_i(ffb), .torque_ref_i(tq), .speed_ref_i(spd),
    .accel_ref_i(acc), .poserr_i(perr), .feedforward_o(ffo), .torque_filt_o(tfo),
    .p_control_o(pctl));
  sfm_host_model host (.clk_i(clk_i), .ack_i(ack), .dat_i(rdat), .cyc_o(cyc), .stb_o(stb),
    .we_o(we), .adr_o(adr), .dat_o(wdat), .sel_o(sel));
  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task automatic close_out;
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    host.xfer(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  // Drive loop inputs on an edge, then sample p control once it has settled
  task automatic pchk(input logic signed [31:0] t, s, ac, pe, input logic e);
    @(posedge clk_i);
    tq <= t;
    spd <= s;
    acc <= ac;
    perr <= pe;
    repeat (2) @(posedge clk_i);
    #1;
    chk({31'h0, pctl}, {31'h0, e});
  endtask
  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    for (int i = 0; i < 9; i++) rdchk(ofs[i], rstv[i]);
    for (int i = 0; i < 9; i++) wr(ofs[i], 32'hFFFF_FFFF);
    for (int i = 0; i < 9; i++) rdchk(ofs[i], topv[i]);
    wr(8'h28, 32'h1234_5678);
    rdchk(8'h28, 32'h0);
  endtask
  task automatic t_torque;
    wr(SFM_SW_SEL_OFS, 32'(SFM_SW_TORQUE));
    wr(SFM_TQ_LVL_OFS, SFM_TQ_LVL_RST);
    pchk(200, 0, 0, 0, 1'b0);
    pchk(201, 0, 0, 0, 1'b1);
    pchk(-201, 0, 0, 0, 1'b1);
    pchk(200, 9999, 9999, 9999, 1'b0);
  endtask
  task automatic t_select;
    wr(SFM_SPD_LVL_OFS, 32'h32);
    wr(SFM_ACC_LVL_OFS, 32'h32);
    wr(SFM_PERR_LVL_OFS, 32'h32);
    wr(SFM_SW_SEL_OFS, 32'(SFM_SW_SPEED));
    pchk(999, 0, 51, 51, 1'b0);
    pchk(0, -51, 0, 0, 1'b1);
    wr(SFM_SW_SEL_OFS, 32'(SFM_SW_ACCEL));
    pchk(999, 50, 50, 0, 1'b0);
    pchk(0, 0, 51, 0, 1'b1);
    wr(SFM_SW_SEL_OFS, 32'(SFM_SW_POSERR));
    pchk(999, 99, 99, 50, 1'b0);
    pchk(0, 0, 0, -51, 1'b1);
    rdchk(SFM_STATUS_OFS, 32'h0000_0003);
    @(posedge clk_i);
    pos <= 1'b0;
    pchk(0, 0, 0, 99, 1'b0);
    @(posedge clk_i);
    pos <= 1'b1;
    wr(SFM_SW_SEL_OFS, 32'(SFM_SW_OFF));
    pchk(999, 999, 999, 999, 1'b0);
    wr(SFM_SW_SEL_OFS, 32'h0000_000F);
    pchk(999, 999, 999, 999, 1'b0);
  endtask
  task automatic t_ff;
    int n;
    wr(SFM_FF_TIME_OFS, 32'h0);
    wr(SFM_FF_GAIN_OFS, 32'h50);
    ffb <= 1000;
    repeat (2600) @(posedge clk_i);
    #1;
    chk(ffo, 32'd800);
    wr(SFM_FF_GAIN_OFS, 32'h21);
    ffb <= 1001;
    repeat (2600) @(posedge clk_i);
    #1;
    chk(ffo, 32'd330);
    // One-sample time constant halves each step: 330 + (660 - 330) / 2
    wr(SFM_FF_TIME_OFS, 32'h1);
    repeat (20) @(posedge clk_i);
    ffb <= 2001;
    n = 0;
    while (ffo === 32'sd330 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(ffo, 32'd495);
    @(posedge clk_i);
    pos <= 1'b0;
    @(posedge clk_i);
    #1;
    chk(ffo, 32'h0);
    @(posedge clk_i);
    pos <= 1'b1;
  endtask
  task automatic t_filter;
    int n;
    wr(SFM_TQ_LAG_OFS, 32'h0);
    wr(SFM_NOTCH_OFS, 32'hFFFF_F1F1);
    rdchk(SFM_NOTCH_OFS, 32'h0000_0101);
    tq <= 300;
    // Two notch stages need six ticks of history before the output settles
    repeat (8000) @(posedge clk_i);
    #1;
    chk(tfo, 32'd300);
    @(posedge clk_i);
    tq <= 100;
    n = 0;
    while (tfo === 32'sd300 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(tfo, 32'd250);
    wr(SFM_NOTCH_OFS, 32'h0000_0001);
    repeat (3000) @(posedge clk_i);
    #1;
    chk(tfo, 32'd100);
    @(posedge clk_i);
    tq <= 500;
    n = 0;
    while (tfo === 32'sd100 && n < 3000) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(tfo, 32'd300);
  endtask
  // ----------------------------------------------------------------
  // Main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_torque();
    t_select();
    t_ff();
    t_filter();
    close_out();
  end
  // Whole run is under 23000 cycles; the margin covers slow acks
  initial begin
    repeat (60000) @(posedge clk_i);
    miscompares++;
    close_out();
  end
endmodule // testbench
